//--- spo_map.vh
// constants for the serial to parallel output latch
// Function
// - eight-stage shift register feeds eight-bit storage register driving parallel outputs
// - shift and storage registers each have their own independent clock input
// - both clocks act only on rising edges
// - low shift clear zeroes all shift stages at once, overriding shifting
// - on shift edge, first stage takes serial input, others take previous stage
// - on storage edge, all eight shift stages copy into storage register
// - output enable high floats parallel outputs; cascade output keeps driving
// - cascade output carries the last shift stage for chaining
// - with clocks tied, storage captures shift contents from before that edge
// - no reset value; shift contents undefined until cleared or shifted, storage contents until the first storage edge
`ifndef SPO_MAP_VH
`define SPO_MAP_VH
`define SPO_WIDTH 8
`define SPO_FIFO_DEPTH 8
`define SPO_SYNC_STAGES 2
`define SPO_ZERO 8'h00
`define SPO_SYNC_IDLE 5'h12
`endif

//--- spo_latch.v
// serial to parallel output latch with pin sampling and output word fifo
`timescale 1ns/10ps
`include "spo_map.vh"

// =====================================
// fifo
module spo_fifo #(
   parameter WIDTH = `SPO_WIDTH,
   parameter DEPTH = `SPO_FIFO_DEPTH,
   parameter AW = 3
) (
   input wire clk,
   input wire rst_b,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wp_r;
   reg [AW:0] rp_r;
   localparam [AW:0] DEPTH_W = DEPTH;
   wire [AW:0] used = wp_r - rp_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (used != DEPTH_W);
   assign out_valid = (used != {(AW+1){1'b0}});
   assign out_data = mem[rp_r[AW-1:0]];
   always @(posedge clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= in_data;
      end
   end
   always @(posedge clk) begin
      if (!rst_b) begin
         wp_r <= {(AW+1){1'b0}};
         rp_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule

// =====================================
// top
module spo_latch #(
   parameter WIDTH = `SPO_WIDTH,
   parameter DEPTH = `SPO_FIFO_DEPTH
) (
   input wire CLK,
   input wire RST_B,
   input wire SERIAL_IN,
   input wire SHIFT_CLOCK,
   input wire SHIFT_CLEAR_N,
   input wire STORE_CLOCK,
   input wire OUT_ENABLE_N,
   output wire [WIDTH-1:0] PARALLEL_OUT,
   output wire [WIDTH-1:0] PARALLEL_OE,
   output wire CASCADE_OUT,
   output wire WORD_VALID,
   input wire WORD_READY,
   output wire [WIDTH-1:0] WORD_DATA,
   output wire STORE_DROPPED
);
   // =====================================
   // pin synchronisers, first stage read only by second
   reg [4:0] s1_r;
   reg [4:0] s2_r;
   reg sclk_d_r;
   reg rclk_d_r;
   always @(posedge CLK) begin
      if (!RST_B) begin
         // idle levels: outputs floated, clear released, so release shows no false event
         s1_r <= `SPO_SYNC_IDLE;
         s2_r <= `SPO_SYNC_IDLE;
         sclk_d_r <= 1'b0;
         rclk_d_r <= 1'b0;
      end else begin
         s1_r <= {OUT_ENABLE_N, STORE_CLOCK, SHIFT_CLOCK, SHIFT_CLEAR_N, SERIAL_IN};
         s2_r <= s1_r;
         sclk_d_r <= s2_r[2];
         rclk_d_r <= s2_r[3];
      end
   end
   wire serial_in = s2_r[0];
   wire clr_n = s2_r[1];
   wire shift_rise = s2_r[2] && !sclk_d_r;
   wire store_rise = s2_r[3] && !rclk_d_r;
   wire oe_n = s2_r[4];

   // =====================================
   // shift and storage registers, no reset value
   reg [WIDTH-1:0] shift_r;
   reg [WIDTH-1:0] store_r;
   wire fifo_ready;
   // clear wins over a shift edge seen in the same cycle
   always @(posedge CLK) begin
      if (!clr_n) begin
         shift_r <= {WIDTH{1'b0}};
      end else if (shift_rise) begin
         shift_r <= {shift_r[WIDTH-2:0], serial_in};
      end
   end
   // old shift contents captured, so tied clocks lag by one pulse
   always @(posedge CLK) begin
      if (store_rise) begin
         store_r <= shift_r;
      end
   end

   // =====================================
   // outputs
   assign PARALLEL_OUT = store_r;
   assign PARALLEL_OE = {WIDTH{!oe_n}};
   assign CASCADE_OUT = shift_r[WIDTH-1];

   // each stored word is also queued; a full queue drops it and flags it
   reg dropped_r;
   always @(posedge CLK) begin
      if (!RST_B) begin
         dropped_r <= 1'b0;
      end else begin
         dropped_r <= store_rise && !fifo_ready;
      end
   end
   assign STORE_DROPPED = dropped_r;

   spo_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
      .clk(CLK),
      .rst_b(RST_B),
      .in_valid(store_rise),
      .in_ready(fifo_ready),
      .in_data(shift_r),
      .out_valid(WORD_VALID),
      .out_ready(WORD_READY),
      .out_data(WORD_DATA)
   );
endmodule

//--- spo_latch_chk.sv
// latch checker
`timescale 1ns/10ps
module spo_latch_chk (
   input wire CLK,
   input wire RST_B,
   input wire SHIFT_CLEAR_N,
   input wire STORE_CLOCK,
   input wire OUT_ENABLE_N,
   input wire [7:0] PARALLEL_OUT,
   input wire [7:0] PARALLEL_OE,
   input wire CASCADE_OUT,
   input wire WORD_VALID,
   input wire WORD_READY,
   input wire STORE_DROPPED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // storage holds no known value before its first capture, so hold checks wait
   reg armed_r;
   always @(posedge CLK) begin
      if (!RST_B) begin
         armed_r <= 1'b0;
      end else if (STORE_CLOCK) begin
         armed_r <= 1'b1;
      end
   end
   property p_off; OUT_ENABLE_N[*4] |-> PARALLEL_OE == 8'h00; endproperty
   a_off: assert property (p_off) else $error("not floated");
   property p_on; (!OUT_ENABLE_N)[*4] |-> PARALLEL_OE == 8'hff; endproperty
   a_on: assert property (p_on) else $error("not driven");
   property p_hold; (armed_r && !STORE_CLOCK)[*6] |-> $stable(PARALLEL_OUT); endproperty
   a_hold: assert property (p_hold) else $error("moved");
   property p_clr; (!SHIFT_CLEAR_N)[*4] |-> !CASCADE_OUT; endproperty
   a_clr: assert property (p_clr) else $error("not cleared");
   property p_store; $rose(STORE_CLOCK) |-> ##3 (WORD_VALID || STORE_DROPPED); endproperty
   a_store: assert property (p_store) else $error("word lost");
   property p_keep; WORD_VALID && !WORD_READY |=> WORD_VALID; endproperty
   a_keep: assert property (p_keep) else $error("word vanished");
endmodule
bind spo_latch spo_latch_chk u_chk (.*);

//--- spo_ctrl_model.sv
// controller model
`timescale 1ns/10ps
module spo_ctrl_model (input wire CLK,
   output reg SERIAL_IN = 1'h0, SHIFT_CLOCK = 1'h0, STORE_CLOCK = 1'h0);
   // half link period
   task half;
      repeat (4) @(posedge CLK);
   endtask
   task send(input [7:0] w);
      for (int b = 7; b >= 0; b--) begin
         SERIAL_IN <= w[b];
         half;
         SHIFT_CLOCK <= 1'h1;
         half;
         SHIFT_CLOCK <= 1'h0;
      end
      STORE_CLOCK <= 1'h1;
      half;
      STORE_CLOCK <= 1'h0;
      half;
   endtask
   // both clocks from one wire
   task send_tied(input [7:0] w);
      for (int b = 7; b >= 0; b--) begin
         SERIAL_IN <= w[b];
         half;
         SHIFT_CLOCK <= 1'h1;
         STORE_CLOCK <= 1'h1;
         half;
         SHIFT_CLOCK <= 1'h0;
         STORE_CLOCK <= 1'h0;
      end
      half;
      half;
   endtask
endmodule

//--- spo_latch_tb_top.sv
// latch bench
`timescale 1ns/10ps
module spo_latch_tb_top;
   reg CLK = 1'h0, RST_B = 1'h0, SHIFT_CLEAR_N = 1'h1, OUT_ENABLE_N = 1'h1, WORD_READY = 1'h0;
   wire SERIAL_IN, SHIFT_CLOCK, STORE_CLOCK, CASCADE_OUT, WORD_VALID, STORE_DROPPED;
   wire [7:0] PARALLEL_OUT, PARALLEL_OE, WORD_DATA;
   reg [7:0] q [0:8];
   reg [7:0] w;
   reg [7:0] n_drop = 8'h00;
   integer i, n_errors = 0, num_checks = 0;
   spo_ctrl_model p (.*);
   spo_latch u_dut (.*);
   initial forever #5 CLK = ~CLK;
   always @(posedge CLK) if (STORE_DROPPED) n_drop <= n_drop + 8'h01;
   // tied clocks: storage takes the contents one pulse behind
   function [7:0] tied_exp(input [7:0] prev, input [7:0] d);
      tied_exp = {prev[0], d[7:1]};
   endfunction
   task chk(input [7:0] s, input [7:0] e);
      num_checks++;
      if (s !== e) n_errors++;
      if (s !== e) $display("ERROR %0t mismatch %h %h", $time, s, e);
   endtask
   task test_done;
      $display("%0d checks %0d errors", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      i = $urandom(33065);
      repeat (20) @(posedge CLK);
      RST_B <= 1'h1;
      chk(PARALLEL_OE, 8'h00);
      for (i = 0; i < 9; i++) begin
         q[i] = (i == 0) ? 8'h80 : $urandom;
         p.send(q[i]);
         chk(PARALLEL_OUT, q[i]);
         chk({7'h00, CASCADE_OUT}, {7'h00, q[i][7]});
      end
      chk(n_drop, 8'h01);
      WORD_READY <= 1'h1;
      for (i = 0; i < 8; i++) begin
         @(negedge CLK);
         chk({7'h00, WORD_VALID}, 8'h01);
         chk(WORD_DATA, q[i]);
         @(posedge CLK);
      end
      SHIFT_CLEAR_N <= 1'h0;
      repeat (8) @(posedge CLK);
      chk(PARALLEL_OUT, q[8]);
      chk({7'h00, CASCADE_OUT}, 8'h00);
      OUT_ENABLE_N <= 1'h0;
      p.send($urandom);
      chk(PARALLEL_OUT, 8'h00);
      chk(PARALLEL_OE, 8'hff);
      SHIFT_CLEAR_N <= 1'h1;
      repeat (4) @(posedge CLK);
      w = $urandom;
      p.send_tied(w);
      chk(PARALLEL_OUT, tied_exp(8'h00, w));
      chk({7'h00, CASCADE_OUT}, {7'h00, w[7]});
      test_done;
   end
endmodule
